//--- logic/dual_timer_control.sv
// Register front end, pin synchronisers and interrupt logic of two timers.
// Assumes an Avalon-MM master on mclk and asynchronous pins.
//
// Overview of operation
// - Control bit 6 reads 1 while system clock runs from timer oscillator.
// - First timer prescale field 11/10/01/00 divides by 8/4/2/1.
// - Clearing the oscillator enable bit turns the oscillator inverter off.
// - Internal source selected means sync-off bit ignored, internal clock used.
// - Source bit 1 counts pin rising edges; 0 counts system clock over four.
// - First timer runs while its run bit is set, stops otherwise.
// - Second timer postscale divides by one plus the four-bit field.
// - Second timer runs while its run bit is set, held otherwise.
// - Reset loads the second timer period register with all ones.
// - Reset clears the second timer count register.
// - Flag bit 0 first timer, bit 1 second timer; cleared on reset.
// - Matching enable bits for both timer interrupts, cleared on reset.
module dual_timer_control
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_timer_clock_pin,
  input wire logic sysclk_from_timer1_osc,
  output logic timer1_osc_inverter_enable,
  output logic irq
);
  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'b00) && (addr[9:2] == idx);
  endfunction

  timer_link_if lnk ();

  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_level_q;
  logic st_s1_q;
  logic st_s2_q;
  logic st_s3_q;
  logic st_level_q;
  logic [INST_CNT_W-1:0] div_q;
  logic inst_tick_q;
  logic ext_pending_q;
  logic ext_pending_d;
  logic t1_edge_q;
  logic t1_edge_d;
  bus_state_type bus_q;
  bus_state_type bus_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] intctl_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [7:0] enables_q;
  logic [7:0] t1ctl_q;
  logic [7:0] t2ctl_q;
  logic [7:0] t2per_q;
  logic osc_en_q;
  logic irq_q;

  // Pin synchronisers
  wire pin_agree = pin_s2_q == pin_s3_q;
  wire pin_rise = pin_agree && pin_s3_q && !pin_level_q;
  wire st_agree = st_s2_q == st_s3_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_level_q <= 1'b0;
    end else begin
      pin_s1_q <= external_timer_clock_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_level_q <= pin_agree ? pin_s3_q : pin_level_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_s1_q <= 1'b0;
      st_s2_q <= 1'b0;
      st_s3_q <= 1'b0;
      st_level_q <= 1'b0;
    end else begin
      st_s1_q <= sysclk_from_timer1_osc;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      st_level_q <= st_agree ? st_s3_q : st_level_q;
    end
  end

  // Instruction clock tick, system clock over four
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      inst_tick_q <= 1'b0;
    end else begin
      div_q <= div_q + INST_CNT_W'(1);
      inst_tick_q <= div_q == INST_LAST;
    end
  end

  // External edge, held to the next tick when synchronised
  wire sync_on = !t1ctl_q[T1_SYNC_OFF_BIT];
  assign ext_pending_d = sync_on && !inst_tick_q && (ext_pending_q || pin_rise);
  assign t1_edge_d = sync_on ? inst_tick_q && (ext_pending_q || pin_rise) : pin_rise;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_pending_q <= 1'b0;
      t1_edge_q <= 1'b0;
    end else begin
      ext_pending_q <= ext_pending_d;
      t1_edge_q <= t1_edge_d;
    end
  end

  // Address decode
  wire sel_intctl = reg_hit(avs_address, IDX_INTERRUPT_MASTER_CONTROL);
  wire sel_flags = reg_hit(avs_address, IDX_PERIPHERAL_IRQ_FLAGS);
  wire sel_t1ctl = reg_hit(avs_address, IDX_TIMER1_CONTROL);
  wire sel_t2cnt = reg_hit(avs_address, IDX_TIMER2_COUNT);
  wire sel_t2ctl = reg_hit(avs_address, IDX_TIMER2_CONTROL);
  wire sel_enables = reg_hit(avs_address, IDX_PERIPHERAL_IRQ_ENABLES);
  wire sel_t2per = reg_hit(avs_address, IDX_TIMER2_PERIOD);
  wire sel_t1lo = reg_hit(avs_address, IDX_TIMER1_COUNT_LOW);
  wire sel_t1hi = reg_hit(avs_address, IDX_TIMER1_COUNT_HIGH);

  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_go = avs_write && (bus_q == BUS_ACK) && avs_byteenable[0];
  wire [7:0] t1ctl_rd = t1ctl_q | (st_level_q ? T1_STATUS_MASK : 8'h00);

  wire [7:0] rd_byte =
    sel_intctl ? intctl_q :
    sel_flags ? {6'h00, flags_q} :
    sel_t1ctl ? t1ctl_rd :
    sel_t2cnt ? lnk.t2_count :
    sel_t2ctl ? t2ctl_q :
    sel_enables ? enables_q :
    sel_t2per ? t2per_q :
    sel_t1lo ? lnk.t1_count[7:0] :
    sel_t1hi ? lnk.t1_count[15:8] :
    8'h00;

  // Bus handshake, one wait cycle per access
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      bus_q <= bus_d;
      wait_q <= bus_d != BUS_ACK;
      if (bus_q == BUS_IDLE && avs_read) begin
        rdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // Software registers
  wire [1:0] flag_set = {lnk.t2_event, lnk.t1_overflow};
  wire [1:0] flag_clr = (wr_go && sel_flags) ? wbyte[1:0] : 2'h0;
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      intctl_q <= RST_CTL;
      flags_q <= RST_FLAGS;
      enables_q <= RST_ENABLES;
      t1ctl_q <= RST_CTL;
      t2ctl_q <= RST_CTL;
      t2per_q <= RST_T2_PERIOD;
    end else begin
      flags_q <= flags_d;
      if (wr_go && sel_intctl) begin
        intctl_q <= wbyte;
      end
      if (wr_go && sel_enables) begin
        enables_q <= wbyte;
      end
      if (wr_go && sel_t1ctl) begin
        t1ctl_q <= wbyte & T1CTL_WMASK;
      end
      if (wr_go && sel_t2ctl) begin
        t2ctl_q <= wbyte & T2CTL_WMASK;
      end
      if (wr_go && sel_t2per) begin
        t2per_q <= wbyte;
      end
    end
  end

  // Oscillator control and interrupt output
  wire [1:0] irq_pending = flags_q & enables_q[1:0];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      osc_en_q <= t1ctl_q[T1_OSC_EN_BIT];
      irq_q <= |irq_pending;
    end
  end

  // Timer units
  assign lnk.inst_tick = inst_tick_q;
  assign lnk.t1_edge = t1_edge_q;
  assign lnk.t1_ctl = t1ctl_q;
  assign lnk.t1_load_lo = wr_go && sel_t1lo;
  assign lnk.t1_load_hi = wr_go && sel_t1hi;
  assign lnk.load_data = wbyte;
  assign lnk.t2_ctl = t2ctl_q;
  assign lnk.t2_period = t2per_q;
  assign lnk.t2_load = wr_go && sel_t2cnt;

  timer1_unit u_timer1 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .lnk(lnk.t1)
  );

  timer2_unit u_timer2 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .lnk(lnk.t2)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign timer1_osc_inverter_enable = osc_en_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_STATUS_READ: assert property (
      bus_q == BUS_IDLE && avs_read && sel_t1ctl
      |=> avs_readdata[T1_STATUS_BIT] == $past(st_level_q))
    else $error("timer clock status bit misread");

  AST_OSC_OFF: assert property (
      wr_go && sel_t1ctl && !wbyte[T1_OSC_EN_BIT] |-> ##2 !timer1_osc_inverter_enable)
    else $error("oscillator inverter still on after disable");

  AST_SYNC_TICK: assert property (
      t1_edge_q && !$past(t1ctl_q[T1_SYNC_OFF_BIT]) |-> $past(inst_tick_q))
    else $error("synchronised edge not on instruction tick");

  AST_UNSYNC_PASS: assert property (
      t1ctl_q[T1_SYNC_OFF_BIT] && pin_rise |=> t1_edge_q)
    else $error("unsynchronised edge not passed");

  AST_INTERNAL_TICK: assert property (
      inst_tick_q |=> !inst_tick_q [*3])
    else $error("instruction tick not one in four");

  AST_FLAG_SET_WINS: assert property (lnk.t1_overflow |=> flags_q[FLAG_T1_BIT])
    else $error("first timer flag lost");

  AST_FLAG2_SET: assert property (lnk.t2_event |=> flags_q[FLAG_T2_BIT])
    else $error("second timer flag lost");

  AST_IRQ_LEVEL: assert property (irq_pending != 2'h0 |=> irq)
    else $error("enabled flag did not raise interrupt");

  AST_PERIOD_RESET: assert property ($fell(sys_rst) |-> t2per_q == RST_T2_PERIOD)
    else $error("period register not all ones after reset");

  AST_ONE_WAIT: assert property (
      bus_q == BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  COV_T1_OVERFLOW: cover property (lnk.t1_overflow);
  COV_T2_EVENT: cover property (lnk.t2_event && t2ctl_q[T2_POST_LSB +: 4] != 4'h0);
  COV_IRQ: cover property ($rose(irq));
  COV_EXT_EDGE: cover property (t1ctl_q[T1_SRC_BIT] && t1_edge_q);
endmodule

//--- include/timer_pkg.sv
// Constants, field layout and helpers shared by the dual timer block.
// Assumes a single system clock and word-indexed register offsets.
package timer_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned INST_DIV = 4;
  localparam int unsigned INST_CNT_W = $clog2(INST_DIV);
  localparam logic [INST_CNT_W-1:0] INST_LAST = INST_CNT_W'(INST_DIV - 1);

  localparam logic [7:0] IDX_INTERRUPT_MASTER_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_TIMER1_CONTROL = 8'h10;
  localparam logic [7:0] IDX_TIMER2_COUNT = 8'h11;
  localparam logic [7:0] IDX_TIMER2_CONTROL = 8'h12;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h20;
  localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h21;

  localparam int unsigned T1_RUN_BIT = 0;
  localparam int unsigned T1_SRC_BIT = 1;
  localparam int unsigned T1_SYNC_OFF_BIT = 2;
  localparam int unsigned T1_OSC_EN_BIT = 3;
  localparam int unsigned T1_PS_LSB = 4;
  localparam int unsigned T1_STATUS_BIT = 6;
  localparam int unsigned T2_PS_LSB = 0;
  localparam int unsigned T2_RUN_BIT = 2;
  localparam int unsigned T2_POST_LSB = 3;
  localparam int unsigned FLAG_T1_BIT = 0;
  localparam int unsigned FLAG_T2_BIT = 1;

  localparam logic [7:0] T1CTL_WMASK = 8'h3F;
  localparam logic [7:0] T1_STATUS_MASK = 8'(1 << T1_STATUS_BIT);
  localparam logic [7:0] T2CTL_WMASK = 8'h7F;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_T2_COUNT = 8'h00;
  localparam logic [7:0] RST_T2_PERIOD = 8'hFF;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [15:0] RST_T1_COUNT = 16'h0000;

  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_type;

  // Low-bit mask that marks the last input of a prescale cycle
  function automatic logic [2:0] t1_prescale_mask(input logic [1:0] ps);
    return 3'((4'h1 << ps) - 4'h1);
  endfunction

  function automatic logic [3:0] t2_prescale_mask(input logic [1:0] ps);
    return ps[1] ? 4'hF : (ps[0] ? 4'h3 : 4'h0);
  endfunction
endpackage

//--- include/timer_link_if.sv
// Carrier between the register front end and the two timer units.
// Assumes every signal is driven and sampled on the system clock.
interface timer_link_if;
  logic inst_tick;
  logic t1_edge;
  logic [7:0] t1_ctl;
  logic t1_load_lo;
  logic t1_load_hi;
  logic [7:0] load_data;
  logic [15:0] t1_count;
  logic t1_overflow;
  logic [7:0] t2_ctl;
  logic [7:0] t2_period;
  logic t2_load;
  logic [7:0] t2_count;
  logic t2_event;

  modport ctrl (
    output inst_tick, t1_edge, t1_ctl, t1_load_lo, t1_load_hi, load_data,
    output t2_ctl, t2_period, t2_load,
    input t1_count, t1_overflow, t2_count, t2_event
  );
  modport t1 (
    input inst_tick, t1_edge, t1_ctl, t1_load_lo, t1_load_hi, load_data,
    output t1_count, t1_overflow
  );
  modport t2 (
    input inst_tick, t2_ctl, t2_period, t2_load, load_data,
    output t2_count, t2_event
  );
endinterface

//--- logic/timer1_unit.sv
// First timer: source select, prescaler and 16-bit up counter.
// Assumes the external edge arrives already synchronised as needed.
module timer1_unit
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  timer_link_if.t1 lnk
);
  logic [2:0] pre_q;
  logic [15:0] cnt_q;
  logic ovf_q;
  wire run = lnk.t1_ctl[T1_RUN_BIT];
  wire load = lnk.t1_load_lo || lnk.t1_load_hi;
  wire src_tick = lnk.t1_ctl[T1_SRC_BIT] ? lnk.t1_edge : lnk.inst_tick;
  wire [2:0] mask = t1_prescale_mask(lnk.t1_ctl[T1_PS_LSB +: 2]);
  wire pre_done = src_tick && ((pre_q & mask) == mask);
  wire count_go = run && pre_done && !load;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 3'h0;
      cnt_q <= RST_T1_COUNT;
      ovf_q <= 1'b0;
    end else begin
      pre_q <= !run ? 3'h0 : (src_tick ? pre_q + 3'h1 : pre_q);
      ovf_q <= count_go && (cnt_q == 16'hFFFF);
      if (lnk.t1_load_lo) begin
        cnt_q[7:0] <= lnk.load_data;
      end else if (lnk.t1_load_hi) begin
        cnt_q[15:8] <= lnk.load_data;
      end else if (count_go) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign lnk.t1_count = cnt_q;
  assign lnk.t1_overflow = ovf_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_T1_HOLD: assert property (!run && !load |=> $stable(cnt_q))
    else $error("first timer moved while stopped");
  AST_T1_DIRECT: assert property (run && !lnk.t1_ctl[T1_SRC_BIT]
      && lnk.t1_ctl[T1_PS_LSB +: 2] == 2'b00 && lnk.inst_tick && !load
      |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("first timer 1:1 count missed");
endmodule

//--- logic/timer2_unit.sv
// Second timer: prescaler, period match counter and postscaler.
// Assumes the instruction tick is a one-cycle pulse on the system clock.
module timer2_unit
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  timer_link_if.t2 lnk
);
  logic [3:0] pre_q;
  logic [3:0] post_q;
  logic [7:0] cnt_q;
  logic evt_q;
  wire run = lnk.t2_ctl[T2_RUN_BIT];
  wire [3:0] post_last = lnk.t2_ctl[T2_POST_LSB +: 4];
  wire [3:0] mask = t2_prescale_mask(lnk.t2_ctl[T2_PS_LSB +: 2]);
  wire pre_done = lnk.inst_tick && ((pre_q & mask) == mask);
  wire step = run && pre_done && !lnk.t2_load;
  wire match = step && (cnt_q == lnk.t2_period);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 4'h0;
      post_q <= 4'h0;
      cnt_q <= RST_T2_COUNT;
      evt_q <= 1'b0;
    end else begin
      pre_q <= !run ? 4'h0 : (lnk.inst_tick ? pre_q + 4'h1 : pre_q);
      evt_q <= match && (post_q == post_last);
      if (match) begin
        post_q <= (post_q == post_last) ? 4'h0 : post_q + 4'h1;
      end
      if (lnk.t2_load) begin
        cnt_q <= lnk.load_data;
      end else if (step) begin
        cnt_q <= match ? 8'h00 : cnt_q + 8'h01;
      end
    end
  end

  assign lnk.t2_count = cnt_q;
  assign lnk.t2_event = evt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_T2_WRAP: assert property (match |=> cnt_q == 8'h00)
    else $error("second timer did not restart at period");
  AST_T2_POST: assert property (evt_q |-> $past(post_q) == $past(post_last))
    else $error("second timer event before postscale done");
  AST_T2_HOLD: assert property (!run && !lnk.t2_load |=> $stable(cnt_q))
    else $error("second timer moved while off");
  AST_T2_CNT_RESET: assert property ($fell(sys_rst) |-> cnt_q == RST_T2_COUNT)
    else $error("second timer count not cleared by reset");
endmodule

//--- verif/tb.sv
// Self-checking bench for the dual timer register block.
// Assumes one 20 MHz clock and an Avalon-MM slave with one wait cycle.
module tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0;
  logic sys_rst, avs_read, avs_write, ext_pin, osc_sel, avs_waitrequest, osc_en, irq;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv, c2;
  logic [3:0] avs_byteenable, q;
  logic [15:0] cnt;
  logic [7:0] r, p;
  logic [1:0] ps;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 71;
  int w, n, e, k;
  localparam logic [7:0] RIDX [9] = '{8'h0B, 8'h0C, 8'h10, 8'h11, 8'h12, 8'h8C, 8'h92, 8'h20,
    8'h21};
  localparam logic [7:0] WIDX [6] = '{8'h0B, 8'h8C, 8'h92, 8'h11, 8'h10, 8'h12};
  localparam logic [7:0] WMASK [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7F};

  dual_timer_control dual_timer_control_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .external_timer_clock_pin(ext_pin),
    .sysclk_from_timer1_osc(osc_sel),
    .timer1_osc_inverter_enable(osc_en),
    .irq(irq)
  );

  always #25 mclk = ~mclk;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0h", what, lo, hi, got);
    end
  endtask

  task automatic cyc(input int cnt_n);
    repeat (cnt_n) @(posedge mclk);
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic xfer(input logic [9:0] a, input logic wr_n, input logic [7:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_read <= !wr_n;
    avs_write <= wr_n;
    avs_writedata <= {24'($random(seed)), d};
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer({i, 2'b00}, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] i);
    xfer({i, 2'b00}, 1'b0, 8'h00, 4'hF);
  endtask

  // Slow random-width pulses on the timer clock pin
  task automatic pulses(input int np);
    repeat (np) begin
      ext_pin <= 1'b1;
      cyc(8 + ($random(seed) & 3));
      ext_pin <= 1'b0;
      cyc(8 + ($random(seed) & 3));
    end
  endtask

  function automatic int t2div(input logic [1:0] s);
    return s[1] ? 16 : (s[0] ? 4 : 1);
  endfunction

  task automatic check_resets();
    foreach (RIDX[j]) begin
      rd(RIDX[j]);
      chk("reset value", {24'h0, RIDX[j] == 8'h92 ? 8'hFF : 8'h00}, rv);
    end
    chk("irq after reset", 32'h0, irq);
    chk("osc enable after reset", 32'h0, osc_en);
  endtask

  // Watchdog sized well above the at most about 21k cycles the tests need
  initial begin
    cyc(50000);
    n_fail++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    ext_pin = 1'b0;
    osc_sel = 1'b0;
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    check_resets();
    foreach (WIDX[j]) begin
      r = 8'($random(seed));
      // Timer2 kept off here so its postscaler starts from zero later
      if (WIDX[j] == 8'h12) begin
        r[2] = 1'b0;
      end
      wr(WIDX[j], r);
      rd(WIDX[j]);
      chk("read back", {24'h0, r & WMASK[j]}, rv);
    end
    wr(8'h10, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h8C, 8'h00);
    wr(8'h0C, 8'hFF);
    // Refused writes: misaligned, byte lane off, unmapped
    wr(8'h92, 8'hA5);
    xfer(10'h249, 1'b1, 8'h3C, 4'hF);
    xfer(10'h248, 1'b1, 8'h3C, 4'hE);
    wr(8'h93, 8'h3C);
    rd(8'h92);
    chk("period after refused writes", 32'hA5, rv);
    xfer(10'h24A, 1'b0, 8'h00, 4'hF);
    chk("misaligned read", 32'h0, rv);
    rd(8'h13);
    chk("unmapped read", 32'h0, rv);
    osc_sel <= 1'b1;
    cyc(6);
    rd(8'h10);
    chk("clock status bit", 32'h40, rv);
    osc_sel <= 1'b0;
    wr(8'h10, 8'h08);
    cyc(2);
    chk("osc enable on", 32'h1, osc_en);
    wr(8'h10, 8'h00);
    cyc(2);
    chk("osc enable off", 32'h0, osc_en);
    // Internal source at each prescale, pin toggling meanwhile
    for (int i = 0; i < 4; i++) begin
      w = 256 << i;
      wr(8'h20, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h10, 8'(i << 4) | 8'h05);
      fork
        cyc(w);
        pulses(w / 24);
      join
      wr(8'h10, 8'(i << 4) | 8'h04);
      rd(8'h20);
      cnt[7:0] = rv[7:0];
      rd(8'h21);
      cnt[15:8] = rv[7:0];
      e = (w + 3) / (4 << i);
      chk_rng("timer1 internal count", e - 1, e + 1, {16'h0, cnt});
      cyc(30);
      rd(8'h20);
      chk("timer1 stopped", {24'h0, cnt[7:0]}, rv);
    end
    // External source, synchronised then direct
    for (int i = 0; i < 2; i++) begin
      wr(8'h20, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h10, 8'(i << 2) | 8'h03);
      n = 3 + ($random(seed) & 7);
      pulses(n);
      cyc(12);
      rd(8'h20);
      chk("external edge count", n, rv);
    end
    wr(8'h21, 8'hFF);
    wr(8'h20, 8'hFF);
    pulses(1);
    cyc(12);
    rd(8'h0C);
    chk("overflow flag", 32'h1, rv);
    wr(8'h8C, 8'h01);
    cyc(2);
    chk("irq enabled", 32'h1, irq);
    wr(8'h8C, 8'h02);
    cyc(2);
    chk("irq masked", 32'h0, irq);
    wr(8'h8C, 8'h01);
    wr(8'h0C, 8'h01);
    cyc(2);
    chk("irq after clear", 32'h0, irq);
    rd(8'h0C);
    chk("flag after clear", 32'h0, rv);
    wr(8'h10, 8'h00);
    // Second timer over every prescale and both postscale ends
    for (int i = 0; i < 6; i++) begin
      ps = 2'(i);
      q = (i == 4) ? 4'h0 : (i == 5) ? 4'hF : 4'($random(seed));
      p = 8'(2 + ($random(seed) & 3));
      wr(8'h12, 8'h00);
      wr(8'h11, 8'h00);
      wr(8'h0C, 8'h02);
      wr(8'h8C, 8'h02);
      wr(8'h92, p);
      wr(8'h12, {1'b0, q, 1'b1, ps});
      e = (p + 1) * t2div(ps) * (q + 1) * 4;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (irq !== 1'b1 && k < 20000);
      chk_rng("timer2 event time", e - 8, e + 8, k);
      rd(8'h11);
      chk_rng("timer2 count", 0, p, rv);
      wr(8'h12, {1'b0, q, 1'b0, ps});
      rd(8'h11);
      c2 = rv;
      cyc(40);
      rd(8'h11);
      chk("timer2 held", c2, rv);
    end
    // Reset again in mid-run
    wr(8'h92, 8'h5A);
    wr(8'h11, 8'h33);
    wr(8'h10, 8'h0F);
    sys_rst <= 1'b1;
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    check_resets();
    results();
  end
endmodule
